// ==== hw/pss_cfg.svh ====
// Constants for the package sleep state sequencer
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_STOP_GRANT_MAX_BCLK   20
`define PSS_PLL_SETTLE_US         15
`define PSS_CLK_MHZ               100
`define PSS_PLL_SETTLE_CYC        ((`PSS_PLL_SETTLE_US) * (`PSS_CLK_MHZ))
`define PSS_ACK_DELAY_CYC         2
`define PSS_VID_NORMAL            7'h20
`define PSS_VID_LOWEST_FREQ       7'h30
`define PSS_VID_DEEPER            7'h40
`define PSS_VID_ENH_DEEPER        7'h48
`define PSS_VID_RETENTION         7'h50
`define PSS_L2_WAYS_RESET         4'h8
`endif

// ==== hw/pss_pkg.sv ====
// Types for the package sleep state sequencer
package pss_pkg;
  typedef enum logic [3:0] {
    PSS_NORMAL      = 4'b0000,
    PSS_STOP_GRANT  = 4'b0001,
    PSS_SG_SNOOP    = 4'b0010,
    PSS_SLEEP       = 4'b0011,
    PSS_DEEP_SLEEP  = 4'b0100,
    PSS_PLL_SETTLE  = 4'b0101,
    PSS_DEEPER      = 4'b0110,
    PSS_ENH_DEEPER  = 4'b0111,
    PSS_RETENTION   = 4'b1000
  } pss_state_type;
  typedef enum logic [2:0] {
    PSS_C0 = 3'b000,
    PSS_C1 = 3'b001,
    PSS_C2 = 3'b010,
    PSS_C3 = 3'b011,
    PSS_C4 = 3'b100,
    PSS_C6 = 3'b110
  } pss_cstate_type;
endpackage

// ==== hw/pss_evt_if.sv ====
// Interrupt latch handshake between sequencer and latch unit
`timescale 1ns/1ps
interface pss_evt_if;
  logic       latch_en;
  logic       service;
  logic       pending;
  logic [3:0] serviced;
  modport seq (output latch_en, output service, input pending, input serviced);
  modport lat (input latch_en, input service, output pending, output serviced);
endinterface

// ==== hw/pss_event_latch.sv ====
// Pending interrupt and monitor event latch
`timescale 1ns/1ps
module pss_event_latch
  import pss_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] event_i,
  pss_evt_if.lat          evt
);
  logic [3:0] held;
  logic [3:0] srv;
  genvar g;
  // ------------------------------------------------------------
  // Event latches, one of each kind kept
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_lat
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          held[g] <= 1'b0;
        end else if (evt.latch_en && event_i[g]) begin
          held[g] <= 1'b1;
        end else if (evt.service) begin
          held[g] <= 1'b0;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          srv[g] <= 1'b0;
        end else begin
          srv[g] <= evt.service && held[g];
        end
      end
    end
  endgenerate
  assign evt.pending  = |held;
  assign evt.serviced = srv;
endmodule // pss_event_latch

// ==== hw/pss_sequencer.sv ====
// Package low-power state sequencer top
`timescale 1ns/1ps
`include "pss_cfg.svh"
// Functional notes
// - Each core reaches Stop-Grant within 20 clocks after acknowledge response.
// - Cores in C2/C3/C4 keep state; restore previous state on stop-clock release.
// - Reset in Stop-Grant initializes but package stays in Stop-Grant.
// - Stop-Grant services snoops, latches interrupts, one of each serviced later.
// - Pending-break asserted in Stop-Grant whenever any event latched.
// - Snoop or interrupt moves to Stop-Grant Snoop until snoop done or an event is latched.
// - Sleep request in Stop-Grant enters Sleep; internal clocks stopped.
// - Sleep neither snoops nor latches; system holds bus quiet.
// - Reset during Sleep resets directly without Stop-Grant.
// - Deep-sleep request during Sleep enters Deep Sleep; clock may stop.
// - 15 us PLL settling after deep-sleep release before counting as Sleep.
// - Deeper-sleep request in Deep Sleep enters Deeper Sleep; drive deeper code.
// - Enhanced sub-state only with L2 fully shut; lower code driven.
// - Deeper Sleep exits to Deep Sleep only when the deeper-sleep request is released.
// - Last core into C4 shrinks L2 stepwise, then asks chipset redirect.
// - Both cores retained and L2 empty: save state, minimum voltage, no snoop.
// - Break event release ramps voltage, restarts PLL, restores cores to active.
// - Package stays Normal while any core is in C0 or C1.
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned PLL_SETTLE_CYC = `PSS_PLL_SETTLE_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       stop_clock_request_n_i,
  input  wire logic       sleep_request_n_i,
  input  wire logic       deep_sleep_request_n_i,
  input  wire logic       deeper_sleep_request_n_i,
  input  wire logic       system_mgmt_interrupt_n_i,
  input  wire logic       init_n_i,
  input  wire logic [1:0] local_interrupt_pins_i,
  input  wire logic       bus_interrupt_i,
  input  wire logic       monitor_event_i,
  input  wire logic       bus_snoop_i,
  input  wire logic       snoop_done_i,
  input  wire logic       ack_response_i,
  input  wire logic [2:0] core0_req_i,
  input  wire logic [2:0] core1_req_i,
  input  wire logic       lowest_frequency_point_i,
  output logic            pending_break_event_n_o,
  output logic [6:0]      voltage_id_code_o,
  output logic [1:0]      core_stop_granted_o,
  output logic [5:0]      core_state_o,
  output logic            clocks_running_o,
  output logic            snoop_ack_o,
  output logic            redirect_request_o,
  output logic [3:0]      l2_ways_o,
  output logic            state_saved_o,
  output logic            core_restore_o,
  output logic [3:0]      package_state_o,
  output logic [3:0]      events_serviced_o
);
  pss_evt_if evt ();
  pss_state_type  state;
  pss_state_type  next_state;
  pss_cstate_type core_st [2];
  logic [4:0]  grant_cnt;
  logic        grant_arm;
  logic [13:0] settle_cnt;
  logic        from_retention;
  logic        reset_in_sleep;
  logic [3:0]  raw_events;
  logic        c4_both;
  logic        c6_both;
  logic        wake_req;

  function automatic logic is_active(input logic [2:0] c);
    return (c == PSS_C0) || (c == PSS_C1);
  endfunction

  assign raw_events = {!system_mgmt_interrupt_n_i, !init_n_i,
                       |(~local_interrupt_pins_i) || bus_interrupt_i,
                       monitor_event_i};
  assign c4_both  = (core0_req_i[2]) && (core1_req_i[2]);
  assign c6_both  = (core0_req_i == PSS_C6) && (core1_req_i == PSS_C6);
  assign wake_req = !c4_both || !lowest_frequency_point_i;

  pss_event_latch u_latch (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .event_i   (raw_events),
    .evt       (evt)
  );

  // ------------------------------------------------------------
  // Event latch control
  // ------------------------------------------------------------
  // Latching only in Stop-Grant and its snoop sub-state
  assign evt.latch_en = (state == PSS_STOP_GRANT) || (state == PSS_SG_SNOOP);
  assign evt.service  = (state == PSS_NORMAL);

  // ------------------------------------------------------------
  // Package state machine
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      PSS_NORMAL: begin
        if (!stop_clock_request_n_i && !is_active(core0_req_i) && !is_active(core1_req_i)) begin
          next_state = PSS_STOP_GRANT;
        end
      end
      PSS_STOP_GRANT: begin
        if (stop_clock_request_n_i) begin
          next_state = PSS_NORMAL;
        end else if (!sleep_request_n_i) begin
          next_state = PSS_SLEEP;
        end else if (bus_snoop_i || bus_interrupt_i) begin
          next_state = PSS_SG_SNOOP;
        end
      end
      PSS_SG_SNOOP: begin
        if (snoop_done_i || evt.pending) begin
          next_state = PSS_STOP_GRANT;
        end
      end
      PSS_SLEEP: begin
        if (!deep_sleep_request_n_i) begin
          next_state = PSS_DEEP_SLEEP;
        end else if (sleep_request_n_i) begin
          next_state = PSS_STOP_GRANT;
        end
      end
      PSS_DEEP_SLEEP: begin
        if (deep_sleep_request_n_i) begin
          next_state = PSS_PLL_SETTLE;
        end else if (!deeper_sleep_request_n_i) begin
          next_state = (l2_ways_o == 4'h0) ?
                       (c6_both ? PSS_RETENTION : PSS_ENH_DEEPER) : PSS_DEEPER;
        end
      end
      PSS_DEEPER, PSS_ENH_DEEPER, PSS_RETENTION: begin
        if (deeper_sleep_request_n_i) begin
          next_state = PSS_DEEP_SLEEP;
        end
      end
      PSS_PLL_SETTLE: begin
        if (settle_cnt == 14'h0000) begin
          next_state = PSS_SLEEP;
        end
      end
      default: next_state = PSS_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      // Reset re-initialises but a package in Stop-Grant stays there
      if (state == PSS_STOP_GRANT) begin
        state <= PSS_STOP_GRANT;
      end else begin
        state <= PSS_NORMAL;
      end
    end else if (reset_in_sleep) begin
      state <= PSS_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // Reset from Stop-Grant keeps Stop-Grant; from Sleep goes straight to reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reset_in_sleep <= 1'b0;
    end else begin
      reset_in_sleep <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // PLL settle counter
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      settle_cnt <= 14'h0000;
    end else if (state == PSS_DEEP_SLEEP && deep_sleep_request_n_i) begin
      settle_cnt <= 14'(PLL_SETTLE_CYC - 1);
    end else if (state == PSS_PLL_SETTLE && settle_cnt != 14'h0000) begin
      settle_cnt <= settle_cnt - 14'h0001;
    end
  end

  // ------------------------------------------------------------
  // Stop-Grant entry timing, one counter shared by both cores
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      grant_arm <= 1'b0;
      grant_cnt <= 5'h00;
    end else if (stop_clock_request_n_i) begin
      grant_arm <= 1'b0;
      grant_cnt <= 5'h00;
    end else if (ack_response_i) begin
      grant_arm <= 1'b1;
      grant_cnt <= 5'(`PSS_ACK_DELAY_CYC);
    end else if (grant_arm && grant_cnt != 5'h00) begin
      grant_cnt <= grant_cnt - 5'h01;
    end
  end
  assign core_stop_granted_o = {2{grant_arm && grant_cnt == 5'h00}};

  // ------------------------------------------------------------
  // Core states
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_core
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          core_st[g] <= PSS_C0;
        end else if (core_restore_o) begin
          core_st[g] <= PSS_C0;
        end else if (stop_clock_request_n_i || !grant_arm) begin
          // Low-power cores keep their state through stop-clock and return to it
          core_st[g] <= pss_cstate_type'((g == 0) ? core0_req_i : core1_req_i);
        end
      end
    end
  endgenerate
  assign core_state_o = {core_st[1], core_st[0]};

  // ------------------------------------------------------------
  // L2 shrink, redirect, retention
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      l2_ways_o <= `PSS_L2_WAYS_RESET;
    end else if (state == PSS_NORMAL && !c4_both) begin
      l2_ways_o <= `PSS_L2_WAYS_RESET;
    end else if (c4_both && l2_ways_o != 4'h0 && state != PSS_NORMAL) begin
      l2_ways_o <= l2_ways_o - 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      redirect_request_o <= 1'b0;
      state_saved_o      <= 1'b0;
      from_retention     <= 1'b0;
      core_restore_o     <= 1'b0;
    end else begin
      redirect_request_o <= (l2_ways_o == 4'h0) && c4_both;
      if (state == PSS_RETENTION) begin
        state_saved_o  <= 1'b1;
        from_retention <= 1'b1;
      end
      core_restore_o <= 1'b0;
      if (from_retention && state == PSS_SLEEP && sleep_request_n_i) begin
        core_restore_o <= 1'b1;
        from_retention <= 1'b0;
        state_saved_o  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      voltage_id_code_o <= `PSS_VID_NORMAL;
    end else begin
      case (next_state)
        PSS_DEEPER:     voltage_id_code_o <= `PSS_VID_DEEPER;
        PSS_ENH_DEEPER: voltage_id_code_o <= `PSS_VID_ENH_DEEPER;
        PSS_RETENTION:  voltage_id_code_o <= `PSS_VID_RETENTION;
        PSS_PLL_SETTLE: voltage_id_code_o <= `PSS_VID_LOWEST_FREQ;
        default:        voltage_id_code_o <= `PSS_VID_NORMAL;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pending_break_event_n_o <= 1'b1;
      snoop_ack_o             <= 1'b0;
      clocks_running_o        <= 1'b1;
      if (state == PSS_STOP_GRANT) begin
        package_state_o       <= PSS_STOP_GRANT;
      end else begin
        package_state_o       <= 4'h0;
      end
      events_serviced_o       <= 4'h0;
    end else begin
      pending_break_event_n_o <= !(evt.pending && !stop_clock_request_n_i
                                   && evt.latch_en);
      snoop_ack_o             <= (state == PSS_SG_SNOOP) && bus_snoop_i;
      clocks_running_o        <= (next_state == PSS_NORMAL) || (next_state == PSS_STOP_GRANT)
                                 || (next_state == PSS_SG_SNOOP);
      package_state_o         <= next_state;
      events_serviced_o       <= evt.serviced;
    end
  end
endmodule // pss_sequencer

// ==== verif/pss_sequencer_props.sv ====
// Port checks for the package sleep state sequencer
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_sequencer_props
  import pss_pkg::*;
#(
  parameter int unsigned PLL_SETTLE_CYC = 10
) (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       stop_clock_request_n_i,
  input wire logic       sleep_request_n_i,
  input wire logic       deep_sleep_request_n_i,
  input wire logic       bus_snoop_i,
  input wire logic       snoop_done_i,
  input wire logic       bus_interrupt_i,
  input wire logic       monitor_event_i,
  input wire logic       pending_break_event_n_o,
  input wire logic [6:0] voltage_id_code_o,
  input wire logic [3:0] l2_ways_o,
  input wire logic [3:0] package_state_o
);
  logic [3:0]  st;
  logic        calm;
  int unsigned settle_cnt;
  assign st = package_state_o;
  assign calm = !bus_snoop_i && !bus_interrupt_i && !monitor_event_i && !stop_clock_request_n_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Cycles spent waiting for the PLL
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || st != PSS_PLL_SETTLE) begin
      settle_cnt <= 0;
    end else begin
      settle_cnt <= settle_cnt + 1;
    end
  end
  sleep_entry_a:
    assert property (st == PSS_STOP_GRANT && calm && !sleep_request_n_i |=> st == PSS_SLEEP)
    else $error("sleep not entered");
  deep_entry_a:
    assert property (st == PSS_SLEEP && calm && !sleep_request_n_i && !deep_sleep_request_n_i
      |=> st == PSS_DEEP_SLEEP) else $error("deep sleep not entered");
  enh_voltage_a:
    assert property (st == PSS_ENH_DEEPER |-> voltage_id_code_o == `PSS_VID_ENH_DEEPER
      && l2_ways_o == 4'h0) else $error("enhanced deeper code wrong");
  retention_voltage_a:
    assert property (st == PSS_RETENTION |-> voltage_id_code_o == `PSS_VID_RETENTION
      && l2_ways_o == 4'h0) else $error("retention code wrong");
  break_raise_a:
    assert property (st == PSS_STOP_GRANT && monitor_event_i && !stop_clock_request_n_i
      |-> ##[1:3] !pending_break_event_n_o) else $error("pending break not raised");
  snoop_enter_a:
    assert property (st == PSS_STOP_GRANT && bus_snoop_i && !snoop_done_i && sleep_request_n_i
      && !stop_clock_request_n_i |=> st == PSS_SG_SNOOP) else $error("snoop state not entered");
  snoop_hold_a:
    assert property (st == PSS_SG_SNOOP && !snoop_done_i && !bus_interrupt_i
      && !$past(bus_interrupt_i) && pending_break_event_n_o
      && !stop_clock_request_n_i |=> st == PSS_SG_SNOOP) else $error("snoop state left early");
  settle_exit_a:
    assert property ($past(st) == PSS_PLL_SETTLE && st != PSS_PLL_SETTLE |-> st == PSS_SLEEP
      && $past(settle_cnt) + 1 >= PLL_SETTLE_CYC && $past(settle_cnt) <= PLL_SETTLE_CYC + 1)
    else $error("pll settle time wrong");
endmodule // pss_sequencer_props
bind pss_sequencer pss_sequencer_props #(.PLL_SETTLE_CYC(PLL_SETTLE_CYC)) u_props (
  .ref_clk_i, .rstn_i, .stop_clock_request_n_i, .sleep_request_n_i, .deep_sleep_request_n_i,
  .bus_snoop_i, .snoop_done_i, .bus_interrupt_i, .monitor_event_i, .pending_break_event_n_o,
  .voltage_id_code_o, .l2_ways_o, .package_state_o);

// ==== verif/pss_chipset_model.sv ====
// Chipset model stepping the sleep request pins in order
`timescale 1ns/1ps
module pss_chipset_model #(
  parameter int SETTLE = 16
) (
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] depth_i,
  input  wire logic       pending_break_event_n_i,
  output logic [3:0]      request_n_o
);
  logic [2:0] level = 3'h0;
  int         hold  = 0;
  // One pin per step, released in reverse order; bus clock left running
  assign request_n_o = ~{level >= 3'h4, level >= 3'h3, level >= 3'h2, level >= 3'h1};
  always @(negedge ref_clk_i) begin
    if (hold > 0) begin
      hold <= hold - 1;
    end else if (level != 3'h0 && (depth_i < level || !pending_break_event_n_i)) begin
      level <= level - 3'h1;
      hold  <= (level == 3'h3) ? SETTLE : 1;
    end else if (depth_i > level && pending_break_event_n_i === 1'b1) begin
      level <= level + 3'h1;
      hold  <= 1;
    end
  end
endmodule // pss_chipset_model

// ==== verif/pss_sequencer_test.sv ====
// Self-checking bench for the package sleep state sequencer
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_sequencer_test import pss_pkg::*;;
  typedef struct packed {
    logic [2:0] core;
    logic [2:0] depth;
    logic [3:0] st;
    logic [6:0] vid;
  } pss_row_type;
  localparam pss_row_type ROWS [9] = '{
    '{3'h0, 3'h1, 4'h0, 7'h00}, '{3'h2, 3'h1, 4'h1, 7'h00}, '{3'h2, 3'h2, 4'h3, 7'h00},
    '{3'h4, 3'h3, 4'h4, 7'h00}, '{3'h4, 3'h4, 4'h7, `PSS_VID_ENH_DEEPER},
    '{3'h4, 3'h0, 4'h0, 7'h00}, '{3'h4, 3'h3, 4'h4, 7'h00},
    '{3'h6, 3'h4, 4'h8, `PSS_VID_RETENTION}, '{3'h0, 3'h0, 4'h0, 7'h00}};
  logic       clk = 0, rstn = 0, smi_n = 1, mon_ev = 0, snoop = 0, snoop_done = 0, ack = 0;
  logic       bus_int = 0;
  logic [2:0] core = 3'h0, depth = 3'h0;
  logic [3:0] req_n, pstate, l2;
  logic [6:0] vid;
  logic [1:0] granted;
  logic       pbe_n, clk_run, restore;
  int         num_errors = 0, n_tests = 0, restores = 0, i;
  pss_sequencer #(.PLL_SETTLE_CYC(10)) uut (
    .ref_clk_i(clk), .rstn_i(rstn), .stop_clock_request_n_i(req_n[0]),
    .sleep_request_n_i(req_n[1]), .deep_sleep_request_n_i(req_n[2]),
    .deeper_sleep_request_n_i(req_n[3]), .system_mgmt_interrupt_n_i(smi_n), .init_n_i(1'b1),
    .local_interrupt_pins_i(2'b11), .bus_interrupt_i(bus_int), .monitor_event_i(mon_ev),
    .bus_snoop_i(snoop), .snoop_done_i(snoop_done), .ack_response_i(ack), .core0_req_i(core),
    .core1_req_i(core), .lowest_frequency_point_i(1'b1), .pending_break_event_n_o(pbe_n),
    .voltage_id_code_o(vid), .core_stop_granted_o(granted), .core_state_o(),
    .clocks_running_o(clk_run), .snoop_ack_o(), .redirect_request_o(), .l2_ways_o(l2),
    .state_saved_o(), .core_restore_o(restore), .package_state_o(pstate),
    .events_serviced_o());
  pss_chipset_model #(.SETTLE(16)) chipset (.ref_clk_i(clk), .depth_i(depth),
    .pending_break_event_n_i(pbe_n), .request_n_o(req_n));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (restore === 1'b1) restores++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_st(input logic [3:0] st, input int lim);
    int k;
    for (k = 0; k < lim && pstate !== st; k++) @(negedge clk);
    if (k == lim) begin
      check("state wait", 8'(pstate), 8'(st));
      stop_test();
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    foreach (ROWS[k]) begin
      core <= ROWS[k].core;
      if (ROWS[k].vid != 7'h00) begin
        for (i = 0; i < 40 && l2 !== 4'h0; i++) @(negedge clk);
        check("l2 ways", 8'(l2), 8'h00);
      end
      depth <= ROWS[k].depth;
      repeat (4) @(negedge clk);
      wait_st(ROWS[k].st, 300);
      check("package state", 8'(pstate), 8'(ROWS[k].st));
      if (ROWS[k].vid != 7'h00) check("voltage code", 8'(vid), 8'(ROWS[k].vid));
    end
    check("restore pulses", 8'(restores), 8'h01);
    // Snoop, grant and break event in Stop-Grant
    core <= 3'h2;
    depth <= 3'h1;
    wait_st(4'h1, 50);
    ack = 1;
    @(negedge clk);
    ack = 0;
    for (i = 0; i < 20 && granted !== 2'b11; i++) @(negedge clk);
    check("stop granted", 8'(granted), 8'h03);
    snoop = 1;
    @(negedge clk);
    snoop = 0;
    check("snoop state", 8'(pstate), 8'h02);
    @(negedge clk);
    check("snoop held", 8'(pstate), 8'h02);
    snoop_done = 1;
    @(negedge clk);
    snoop_done = 0;
    check("snoop done", 8'(pstate), 8'h01);
    mon_ev = 1;
    smi_n = 0;
    @(negedge clk);
    mon_ev = 0;
    smi_n = 1;
    for (i = 0; i < 3 && pbe_n !== 1'b0; i++) @(negedge clk);
    check("pending break", 8'(pbe_n), 8'h00);
    depth <= 3'h0;
    wait_st(4'h0, 50);
    // Bus interrupt in Stop-Grant: snoop state until latched
    depth <= 3'h1;
    wait_st(4'h1, 50);
    bus_int = 1;
    @(negedge clk);
    bus_int = 0;
    check("interrupt snoop", 8'(pstate), 8'h02);
    @(negedge clk);
    check("interrupt latched", 8'(pstate), 8'h01);
    depth <= 3'h0;
    wait_st(4'h0, 50);
    // Reset taken while in Sleep
    core <= 3'h2;
    depth <= 3'h2;
    wait_st(4'h3, 80);
    rstn = 0;
    depth <= 3'h0;
    repeat (6) @(negedge clk);
    check("reset state", 8'(pstate), 8'h00);
    check("reset voltage", 8'(vid), 8'(`PSS_VID_NORMAL));
    check("reset break", 8'(pbe_n), 8'h01);
    check("reset l2", 8'(l2), 8'(`PSS_L2_WAYS_RESET));
    check("reset clocks", 8'(clk_run), 8'h01);
    rstn = 1;
    @(negedge clk);
    check("after reset", 8'(pstate), 8'h00);
    // Reset taken while in Stop-Grant
    core <= 3'h2;
    depth <= 3'h1;
    wait_st(4'h1, 50);
    rstn = 0;
    depth <= 3'h0;
    repeat (4) @(negedge clk);
    check("reset in grant", 8'(pstate), 8'h01);
    rstn = 1;
    wait_st(4'h0, 10);
    check("grant reset exit", 8'(pstate), 8'h00);
    stop_test();
  end
endmodule // pss_sequencer_test
